/* agcdb_map.svh */
`ifndef AGCDB_MAP_SVH
`define AGCDB_MAP_SVH

`define AGCDB_LEFT_DEBOUNCE_OFS 8'h22
`define AGCDB_RIGHT_DEBOUNCE_OFS 8'h23
`define AGCDB_FLAGS_OFS 8'h24
`define AGCDB_INT_STATUS_OFS 8'h30
`define AGCDB_INT_CLEAR_OFS 8'h31
`define AGCDB_INT_ENABLE_OFS 8'h32

`define AGCDB_REG_RESET 8'h00
`define AGCDB_NOISE_MSB 7
`define AGCDB_NOISE_LSB 3
`define AGCDB_SIG_MSB 2
`define AGCDB_SIG_LSB 0

`define AGCDB_FLAG_PGA_L 7
`define AGCDB_FLAG_PWR_L 6
`define AGCDB_FLAG_SIG_L 5
`define AGCDB_FLAG_SAT_L 4
`define AGCDB_FLAG_PGA_R 3
`define AGCDB_FLAG_PWR_R 2
`define AGCDB_FLAG_SIG_R 1
`define AGCDB_FLAG_SAT_R 0

`define AGCDB_MAX_GAIN_CAP 7'h77
`define AGCDB_THRESH_OFF 5'h00
`define AGCDB_LONG_CODE_FIRST 5'h08
`define AGCDB_LONG_CODE_BASE 12'h007
`define AGCDB_LONG_STEP_SHIFT 7
`define AGCDB_UNITS_ZERO 12'h000
`define AGCDB_UNITS_ONE 12'h001

`define AGCDB_HALF_MS_NS 500000
`define AGCDB_CLK_PERIOD_NS 10
`define AGCDB_HALF_MS_CYCLES (`AGCDB_HALF_MS_NS / `AGCDB_CLK_PERIOD_NS)

`endif

/* agcdb_pkg.sv */
package agcdb_pkg;

    typedef enum logic {
        DET_SIGNAL,
        DET_NOISE
    } agcdb_det_t;

endpackage

/* agcdb_debounce.sv */
`timescale 1ns/1ps
`include "agcdb_map.svh"

module agcdb_debounce (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Detector control
    input wire logic enable,
    input wire logic tick,
    input wire logic raw_below,
    input wire logic [11:0] noise_units,
    input wire logic [11:0] signal_units,
    // Debounced state
    output logic noise_detected
);

    agcdb_pkg::agcdb_det_t state_reg;
    agcdb_pkg::agcdb_det_t state_next;
    logic [11:0] count_reg;
    logic [11:0] count_next;
    logic mismatch;
    logic [11:0] target;

    assign mismatch = raw_below != (state_reg == agcdb_pkg::DET_NOISE);
    assign target = (state_reg == agcdb_pkg::DET_NOISE) ? signal_units : noise_units;

    // The count runs in half-millisecond ticks, so the first tick may be partial.
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        if (!enable) begin
            state_next = agcdb_pkg::DET_SIGNAL;
            count_next = `AGCDB_UNITS_ZERO;
        end else if (!mismatch) begin
            count_next = `AGCDB_UNITS_ZERO;
        end else if (count_reg >= target) begin
            case (state_reg)
                agcdb_pkg::DET_SIGNAL: state_next = agcdb_pkg::DET_NOISE;
                agcdb_pkg::DET_NOISE: state_next = agcdb_pkg::DET_SIGNAL;
                default: state_next = agcdb_pkg::DET_SIGNAL;
            endcase
            count_next = `AGCDB_UNITS_ZERO;
        end else if (tick) begin
            count_next = count_reg + `AGCDB_UNITS_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= agcdb_pkg::DET_SIGNAL;
            count_reg <= `AGCDB_UNITS_ZERO;
            noise_detected <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            noise_detected <= (state_next == agcdb_pkg::DET_NOISE);
        end
    end

    disabled_forces_signal_a: assert property (@(posedge clk) disable iff (rst)
        !enable |=> !noise_detected)
        else $error("Disabled detector did not return to signal state.");

    hold_on_match_a: assert property (@(posedge clk) disable iff (rst)
        (enable && !mismatch) |=> (noise_detected == $past(noise_detected)))
        else $error("Detected state changed without a persisting condition.");

    zero_debounce_flip_a: assert property (@(posedge clk) disable iff (rst)
        (enable && mismatch && target == `AGCDB_UNITS_ZERO) |=> (noise_detected != $past(noise_detected)))
        else $error("Zero debounce did not switch state at once.");

endmodule

/* agcdb_top.sv */
`timescale 1ns/1ps
`include "agcdb_map.svh"

module agcdb_top #(
    parameter int HALF_MS_CYCLES = `AGCDB_HALF_MS_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // Interrupt
    output logic irq,
    // Sample rate mode
    input wire logic double_rate_audio,
    // Left channel state from the record path
    input wire logic left_below_threshold,
    input wire logic [4:0] left_noise_threshold,
    input wire logic [6:0] left_max_gain,
    input wire logic [7:0] left_agc_gain,
    input wire logic [7:0] left_pga_applied,
    input wire logic [7:0] left_pga_programmed,
    input wire logic left_adc_powered,
    // Right channel state from the record path
    input wire logic right_below_threshold,
    input wire logic [4:0] right_noise_threshold,
    input wire logic [6:0] right_max_gain,
    input wire logic [7:0] right_agc_gain,
    input wire logic [7:0] right_pga_applied,
    input wire logic [7:0] right_pga_programmed,
    input wire logic right_adc_powered,
    // Debounced detector state
    output logic left_noise_detected,
    output logic right_noise_detected
);

    // Index 1 is the left channel and index 0 the right, matching the flag nibbles.
    logic [1:0] below;
    logic [1:0][4:0] thresh;
    logic [1:0][6:0] max_gain;
    logic [1:0][7:0] agc_gain;
    logic [1:0][7:0] pga_applied;
    logic [1:0][7:0] pga_programmed;
    logic [1:0] powered;
    logic [1:0][7:0] dbn_reg;
    logic [1:0][11:0] noise_units;
    logic [1:0][11:0] signal_units;
    logic [1:0] det_enable;
    logic [1:0] det_noise;
    logic [1:0] pga_match;
    logic [1:0] sig_status;
    logic [1:0] sat;
    logic [1:0][6:0] gain_cap;
    logic [15:0] tick_cnt_reg;
    logic [15:0] tick_limit;
    logic tick;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] int_status_reg;
    logic [7:0] int_status_next;
    logic [7:0] int_enable_reg;
    logic [7:0] int_enable_next;
    logic [7:0] clear_mask;
    logic [7:0] rd_mux;
    logic wr_int_enable;

    assign below = {left_below_threshold, right_below_threshold};
    assign thresh = {left_noise_threshold, right_noise_threshold};
    assign max_gain = {left_max_gain, right_max_gain};
    assign agc_gain = {left_agc_gain, right_agc_gain};
    assign pga_applied = {left_pga_applied, right_pga_applied};
    assign pga_programmed = {left_pga_programmed, right_pga_programmed};
    assign powered = {left_adc_powered, right_adc_powered};
    assign left_noise_detected = det_noise[1];
    assign right_noise_detected = det_noise[0];

    // Code to half-millisecond units: 0, 1, then powers of two, then 128 per step.
    function automatic logic [11:0] decode_units(input logic [4:0] code);
        logic [11:0] steps;
        steps = {7'h00, code} - `AGCDB_LONG_CODE_BASE;
        if (code == 5'h00) begin
            decode_units = `AGCDB_UNITS_ZERO;
        end else if (code < `AGCDB_LONG_CODE_FIRST) begin
            decode_units = `AGCDB_UNITS_ONE << (code - 5'h01);
        end else begin
            decode_units = steps << `AGCDB_LONG_STEP_SHIFT;
        end
    endfunction

    // Double rate audio halves the timebase, so the debounce times are halved then.
    assign tick_limit = (double_rate_audio && HALF_MS_CYCLES > 1) ?
        16'(HALF_MS_CYCLES / 2) : 16'(HALF_MS_CYCLES);
    assign tick = (tick_cnt_reg >= tick_limit - 16'h0001);

    always_ff @(posedge clk) begin
        if (rst) begin
            tick_cnt_reg <= 16'h0000;
        end else if (tick) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_chan
            logic wr_sel;
            assign wr_sel = wr_en && (addr == ((i == 1) ? `AGCDB_LEFT_DEBOUNCE_OFS : `AGCDB_RIGHT_DEBOUNCE_OFS));
            assign noise_units[i] = decode_units(dbn_reg[i][`AGCDB_NOISE_MSB:`AGCDB_NOISE_LSB]);
            assign signal_units[i] = decode_units({2'b00, dbn_reg[i][`AGCDB_SIG_MSB:`AGCDB_SIG_LSB]});
            assign det_enable[i] = (thresh[i] != `AGCDB_THRESH_OFF);
            assign pga_match[i] = (pga_applied[i] == pga_programmed[i]);
            assign sig_status[i] = det_enable[i] && det_noise[i];
            assign gain_cap[i] = (max_gain[i] > `AGCDB_MAX_GAIN_CAP) ? `AGCDB_MAX_GAIN_CAP : max_gain[i];
            assign sat[i] = (agc_gain[i] == {1'b0, gain_cap[i]});

            always_ff @(posedge clk) begin
                if (rst) begin
                    dbn_reg[i] <= `AGCDB_REG_RESET;
                end else if (wr_sel) begin
                    dbn_reg[i] <= wr_data;
                end
            end

            agcdb_debounce u_agcdb_debounce (
                .clk(clk),
                .rst(rst),
                .enable(det_enable[i]),
                .tick(tick),
                .raw_below(below[i]),
                .noise_units(noise_units[i]),
                .signal_units(signal_units[i]),
                .noise_detected(det_noise[i])
            );
        end
    endgenerate

    // Flags follow the record path only; no register access can reach them.
    assign flags_next = {pga_match[1], powered[1], sig_status[1], sat[1],
                         pga_match[0], powered[0], sig_status[0], sat[0]};

    // Any flag change is an event; a change in the clearing cycle survives the clear.
    assign clear_mask = (wr_en && addr == `AGCDB_INT_CLEAR_OFS) ? wr_data : 8'h00;
    assign int_status_next = (int_status_reg & ~clear_mask) | (flags_next ^ flags_reg);
    assign wr_int_enable = wr_en && (addr == `AGCDB_INT_ENABLE_OFS);
    assign int_enable_next = wr_int_enable ? wr_data : int_enable_reg;

    assign rd_mux = (addr == `AGCDB_LEFT_DEBOUNCE_OFS) ? dbn_reg[1] :
                    (addr == `AGCDB_RIGHT_DEBOUNCE_OFS) ? dbn_reg[0] :
                    (addr == `AGCDB_FLAGS_OFS) ? flags_reg :
                    (addr == `AGCDB_INT_STATUS_OFS) ? int_status_reg :
                    (addr == `AGCDB_INT_ENABLE_OFS) ? int_enable_reg :
                    8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg <= `AGCDB_REG_RESET;
            int_status_reg <= `AGCDB_REG_RESET;
            int_enable_reg <= `AGCDB_REG_RESET;
            irq <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            flags_reg <= flags_next;
            int_status_reg <= int_status_next;
            int_enable_reg <= int_enable_next;
            irq <= |(int_status_next & int_enable_next);
            rd_data <= rd_en ? rd_mux : 8'h00;
        end
    end

    pga_flag_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> (flags_reg[`AGCDB_FLAG_PGA_L] == $past(left_pga_applied == left_pga_programmed)))
        else $error("Left gain match flag wrong.");

    power_flags_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> (flags_reg[`AGCDB_FLAG_PWR_L] == $past(left_adc_powered)
                  && flags_reg[`AGCDB_FLAG_PWR_R] == $past(right_adc_powered)))
        else $error("ADC power flag wrong.");

    sat_cap_a: assert property (@(posedge clk) disable iff (rst)
        (right_max_gain == 7'h7F && right_agc_gain == 8'h77) |=> flags_reg[`AGCDB_FLAG_SAT_R])
        else $error("Saturation not flagged at capped maximum gain.");

    sig_disabled_a: assert property (@(posedge clk) disable iff (rst)
        (left_noise_threshold == 5'h00) |=> !flags_reg[`AGCDB_FLAG_SIG_L])
        else $error("Signal detect flag set while detection is disabled.");

    noise_long_decode_a: assert property (@(posedge clk) disable iff (rst)
        (dbn_reg[1][7:3] == 5'h1F) |-> (noise_units[1] == 12'hC00))
        else $error("Longest noise debounce decoded wrong.");

    noise_short_decode_a: assert property (@(posedge clk) disable iff (rst)
        (dbn_reg[1][7:3] == 5'h07 && dbn_reg[1][2:0] == 3'h1) |-> (noise_units[1] == 12'h040
        && signal_units[1] == 12'h001))
        else $error("Short debounce decoded wrong.");

    right_reg_readback_a: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == 8'h23) ##1 (rd_en && addr == 8'h23 && !wr_en) |=> (rd_data == $past(wr_data, 2)))
        else $error("Right debounce register read back wrong.");

    sticky_kept_a: assert property (@(posedge clk) disable iff (rst)
        !(wr_en && addr == 8'h31) |=> ((int_status_reg & $past(int_status_reg)) == $past(int_status_reg)))
        else $error("Event bit lost without a clear.");

    irq_level_a: assert property (@(posedge clk) disable iff (rst)
        irq == |(int_status_reg & int_enable_reg))
        else $error("Interrupt level disagrees with enabled events.");

    pga_flag_r_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> (flags_reg[`AGCDB_FLAG_PGA_R] == $past(right_pga_applied == right_pga_programmed)))
        else $error("Right gain match flag wrong.");

    sat_flag_l_a: assert property (@(posedge clk) disable iff (rst)
        (left_max_gain <= 7'h77) |=> (flags_reg[`AGCDB_FLAG_SAT_L] == $past(left_agc_gain == {1'b0, left_max_gain})))
        else $error("Left saturation flag wrong.");

    sat_cap_l_a: assert property (@(posedge clk) disable iff (rst)
        (left_max_gain > 7'h77) |=> (flags_reg[`AGCDB_FLAG_SAT_L] == $past(left_agc_gain == 8'h77)))
        else $error("Left saturation flag wrong above the gain cap.");

    sat_flag_r_a: assert property (@(posedge clk) disable iff (rst)
        (right_max_gain <= 7'h77) |=> (flags_reg[`AGCDB_FLAG_SAT_R] == $past(right_agc_gain == {1'b0, right_max_gain})))
        else $error("Right saturation flag wrong.");

    sig_noise_l_a: assert property (@(posedge clk) disable iff (rst)
        (left_noise_detected && left_noise_threshold != 5'h00) |=> flags_reg[`AGCDB_FLAG_SIG_L])
        else $error("Left signal detect flag missed a detected noise state.");

    sig_clear_l_a: assert property (@(posedge clk) disable iff (rst)
        !left_noise_detected |=> !flags_reg[`AGCDB_FLAG_SIG_L])
        else $error("Left signal detect flag set without a detected noise state.");

    sig_noise_r_a: assert property (@(posedge clk) disable iff (rst)
        (right_noise_detected && right_noise_threshold != 5'h00) |=> flags_reg[`AGCDB_FLAG_SIG_R])
        else $error("Right signal detect flag missed a detected noise state.");

    sig_off_r_a: assert property (@(posedge clk) disable iff (rst)
        (right_noise_threshold == 5'h00) |=> !flags_reg[`AGCDB_FLAG_SIG_R])
        else $error("Right signal detect flag set while detection is disabled.");

    left_write_a: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == `AGCDB_LEFT_DEBOUNCE_OFS) |=> (dbn_reg[1] == $past(wr_data)))
        else $error("Left debounce register write lost.");

    right_write_a: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == `AGCDB_RIGHT_DEBOUNCE_OFS) |=> (dbn_reg[0] == $past(wr_data)))
        else $error("Right debounce register write lost.");

    left_kept_a: assert property (@(posedge clk) disable iff (rst)
        !(wr_en && addr == `AGCDB_LEFT_DEBOUNCE_OFS) |=> (dbn_reg[1] == $past(dbn_reg[1])))
        else $error("Left debounce register changed without a write to it.");

    right_kept_a: assert property (@(posedge clk) disable iff (rst)
        !(wr_en && addr == `AGCDB_RIGHT_DEBOUNCE_OFS) |=> (dbn_reg[0] == $past(dbn_reg[0])))
        else $error("Right debounce register changed without a write to it.");

    left_read_a: assert property (@(posedge clk) disable iff (rst)
        (rd_en && addr == `AGCDB_LEFT_DEBOUNCE_OFS) |=> (rd_data == $past(dbn_reg[1])))
        else $error("Left debounce register read back wrong.");

    flags_read_a: assert property (@(posedge clk) disable iff (rst)
        (rd_en && addr == `AGCDB_FLAGS_OFS) |=> (rd_data == $past(flags_reg)))
        else $error("Flag register read back wrong.");

    read_idle_a: assert property (@(posedge clk) disable iff (rst)
        !rd_en |=> (rd_data == 8'h00))
        else $error("Read data not zero outside a read.");

    noise_step_a: assert property (@(posedge clk) disable iff (rst)
        (dbn_reg[0][7:3] == 5'h08) |-> (noise_units[0] == 12'h080))
        else $error("First long noise debounce code decoded wrong.");

    signal_longest_a: assert property (@(posedge clk) disable iff (rst)
        (dbn_reg[0][2:0] == 3'h7) |-> (signal_units[0] == 12'h040))
        else $error("Longest signal debounce decoded wrong.");

    noise_half_a: assert property (@(posedge clk) disable iff (rst)
        (dbn_reg[1][7:3] == 5'h01) |-> (noise_units[1] == 12'h001))
        else $error("Half millisecond noise debounce decoded wrong.");

    zero_code_a: assert property (@(posedge clk) disable iff (rst)
        (dbn_reg[1] == 8'h00) |-> (noise_units[1] == 12'h000 && signal_units[1] == 12'h000))
        else $error("Zero debounce codes decoded wrong.");

    tick_spacing_a: assert property (@(posedge clk) disable iff (rst)
        (tick && !double_rate_audio && HALF_MS_CYCLES > 3) |=> !tick)
        else $error("Timebase ticked on two cycles in a row.");

    event_wins_a: assert property (@(posedge clk) disable iff (rst)
        (flags_next != flags_reg) |=>
        ((int_status_reg & $past(flags_next ^ flags_reg)) == $past(flags_next ^ flags_reg)))
        else $error("Flag change did not set its event bit.");

    event_clear_a: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == `AGCDB_INT_CLEAR_OFS && flags_next == flags_reg) |=>
        ((int_status_reg & $past(wr_data)) == 8'h00))
        else $error("Event clear left a bit set.");

    enable_write_a: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == `AGCDB_INT_ENABLE_OFS) |=> (int_enable_reg == $past(wr_data)))
        else $error("Event enable register write lost.");

endmodule

/* agc_debounce_and_adc_flags_tb.sv */
`timescale 1ns/1ps

module agc_debounce_and_adc_flags_tb;
    // A short tick keeps the longest debounce code within a short run.
    localparam int HC = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic double_rate_audio = 1'b0;
    logic [1:0] below = 2'b00;
    logic [1:0] pwr = 2'b00;
    logic [4:0] thr [2];
    logic [6:0] mg [2];
    logic [7:0] agc [2];
    logic [7:0] pa [2];
    logic [7:0] pp [2];
    logic [7:0] rd_data;
    logic irq;
    logic [1:0] det;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q [$];
    logic [31:0] rnd = 32'hDBA28C2B;
    logic [6:0] m;
    logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h02, 5'h07, 5'h08, 5'h1F};
    int n_errors = 0;
    int total_checks = 0;

    agcdb_top #(.HALF_MS_CYCLES(HC)) u_agcdb_top (
        .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .irq(irq), .double_rate_audio(double_rate_audio),
        .left_below_threshold(below[0]), .left_noise_threshold(thr[0]), .left_max_gain(mg[0]),
        .left_agc_gain(agc[0]), .left_pga_applied(pa[0]), .left_pga_programmed(pp[0]),
        .left_adc_powered(pwr[0]),
        .right_below_threshold(below[1]), .right_noise_threshold(thr[1]), .right_max_gain(mg[1]),
        .right_agc_gain(agc[1]), .right_pga_applied(pa[1]), .right_pga_programmed(pp[1]),
        .right_adc_powered(pwr[1]),
        .left_noise_detected(det[0]), .right_noise_detected(det[1])
    );

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Debounce length in half-millisecond ticks for a noise or signal code.
    function automatic int units(input logic [4:0] c);
        if (c == 5'h00) return 0;
        if (c < 5'h08) return 1 << (c - 1);
        return 128 * (c - 7);
    endfunction

    // Holds only once both detectors sit at their raw input, i.e. with debounce codes of zero.
    function automatic logic [7:0] exp_flags();
        logic [7:0] f;
        logic [6:0] cap;
        f = 8'h00;
        for (int c = 0; c < 2; c++) begin
            cap = (mg[c] > 7'h77) ? 7'h77 : mg[c];
            f[7 - 4 * c -: 4] = {pa[c] == pp[c], pwr[c], below[c] && thr[c] != 5'h00, agc[c] == {1'b0, cap}};
        end
        return f;
    endfunction

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t read data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t output bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    // A write and a read of the same register with no gap between the strobes.
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        exp_q.push_back(d);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    // The first tick may be partial, so the flip lands between t - 1 and t + 1 ticks.
    task automatic settle(input int c, input logic v, input int t, input int p);
        int k;
        int lo;
        k = 0;
        lo = (t == 0) ? 1 : p * (t - 1) + 1;
        while (det[c] !== v && k <= p * t + p + 2) begin
            @(posedge clk);
            #1;
            k++;
        end
        check1(k >= lo && k <= p * t + p + 2, 1'b1);
        // A detector that never settles ends the run here.
        if (det[c] !== v) begin
            end_of_test();
        end
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (rd_seen) begin
            check8(rd_data, exp_q.pop_front());
        end else if (!rst) begin
            check8(rd_data, 8'h00);
        end
        rd_seen <= rd_en;
    end

    initial begin
        for (int c = 0; c < 2; c++) begin
            thr[c] = 5'h01;
            mg[c] = 7'h05;
            agc[c] = 8'h00;
            pa[c] = 8'h00;
            pp[c] = 8'h01;
        end
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd(8'h22, 8'h00);
        rd(8'h23, 8'h00);
        rd(8'h24, exp_flags());
        for (int c = 0; c < 2; c++) begin
            foreach (codes[i]) begin
                wr_rd(c ? 8'h23 : 8'h22, {codes[i], codes[i][2:0]});
                wr(c ? 8'h22 : 8'h23, 8'hFF);
                rd(c ? 8'h23 : 8'h22, {codes[i], codes[i][2:0]});
                @(posedge clk);
                below[c] <= 1'b1;
                settle(c, 1'b1, units(codes[i]), HC);
                @(posedge clk);
                below[c] <= 1'b0;
                settle(c, 1'b0, units({2'b00, codes[i][2:0]}), HC);
            end
        end
        wr(8'h22, 8'h18);
        @(posedge clk);
        below[0] <= 1'b1;
        repeat (3 * HC) @(posedge clk);
        below[0] <= 1'b0;
        @(posedge clk);
        below[0] <= 1'b1;
        settle(0, 1'b1, 4, HC);
        @(posedge clk);
        below[0] <= 1'b0;
        double_rate_audio <= 1'b1;
        settle(0, 1'b0, 0, HC);
        wr(8'h22, 8'h38);
        @(posedge clk);
        below[0] <= 1'b1;
        settle(0, 1'b1, 64, HC / 2);
        @(posedge clk);
        below[0] <= 1'b0;
        double_rate_audio <= 1'b0;
        wr(8'h22, 8'h00);
        wr(8'h23, 8'h00);
        @(posedge clk);
        thr[0] <= 5'h00;
        below[0] <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check1(det[0], 1'b0);
        repeat (24) begin
            @(posedge clk);
            for (int c = 0; c < 2; c++) begin
                rnd = lfsr(rnd);
                m = rnd[12] ? 7'h7F : rnd[19:13];
                pa[c] <= {6'h00, rnd[1:0]};
                pp[c] <= {6'h00, rnd[3:2]};
                pwr[c] <= rnd[4];
                below[c] <= rnd[5];
                thr[c] <= rnd[6] ? rnd[11:7] : 5'h00;
                mg[c] <= m;
                agc[c] <= rnd[20] ? {1'b0, (m > 7'h77) ? 7'h77 : m} : rnd[28:21];
            end
            repeat (4) @(posedge clk);
            rd(8'h24, exp_flags());
        end
        wr(8'h24, ~exp_flags());
        rd(8'h24, exp_flags());
        rd(8'h24, exp_flags());
        wr(8'h31, 8'hFF);
        wr(8'h32, 8'h40);
        rd(8'h30, 8'h00);
        rd(8'h32, 8'h40);
        rd(8'h31, 8'h00);
        rd(8'h5A, 8'h00);
        @(posedge clk);
        pwr[0] <= ~pwr[0];
        repeat (3) @(posedge clk);
        #1;
        check1(irq, 1'b1);
        rd(8'h30, 8'h40);
        wr(8'h31, 8'h40);
        repeat (2) @(posedge clk);
        #1;
        check1(irq, 1'b0);
        wr(8'h32, 8'h00);
        @(posedge clk);
        pwr[1] <= ~pwr[1];
        repeat (3) @(posedge clk);
        #1;
        check1(irq, 1'b0);
        rd(8'h30, 8'h04);
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0) begin
            n_errors++;
        end
        end_of_test();
    end
endmodule
